//--- common/ctcr_pkg.sv
package ctcr_pkg;
  localparam int ADDR_W = 12;
  localparam int TAG_W  = 4;
  localparam int CLK_PERIOD_NS = 8;
  // Fastest-grade timing, in ns
  localparam int T_CYCLE_NS = 20;
  localparam int T_WEW_NS   = 16;
  localparam int T_DS_NS    = 12;
  localparam int T_ACA_NS   = 20;
  localparam int T_DCA_NS   = 12;
  localparam int T_OEA_NS   = 10;
  localparam int T_CLP_NS   = 36;
  // Least times round up, access times are waited out in full as well
  localparam int WEW_CYC  = (T_WEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC   = (T_DS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACA_CYC  = (T_ACA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OEA_CYC  = (T_OEA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AA_CYC   = (T_ACA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLP_CYC  = (T_CLP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_MIN  = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W    = 4;
  localparam logic [1:0] OP_COMPARE = 2'h0;
  localparam logic [1:0] OP_READ    = 2'h1;
  localparam logic [1:0] OP_WRITE   = 2'h2;
  localparam logic [1:0] OP_CLEAR   = 2'h3;
  typedef enum logic [2:0] {
    CTCR_IDLE   = 3'b000,
    CTCR_SETUP  = 3'b001,
    CTCR_STROBE = 3'b011,
    CTCR_WAIT   = 3'b010,
    CTCR_DONE   = 3'b110
  } ctcr_state_t;
endpackage

//--- common/ctcr_tmr_if.sv
`timescale 1ns/1ps
interface ctcr_tmr_if;
  logic                                load;
  logic [ctcr_pkg::CNT_W-1:0]          count;
  logic                                expired;
  modport owner (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface

//--- hdl/ctcr_timer.sv
`timescale 1ns/1ps
module ctcr_timer (
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  ctcr_tmr_if.timer  tmr
);
  logic [ctcr_pkg::CNT_W-1:0] cnt_q;
  logic [ctcr_pkg::CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (tmr.load) begin
      cnt_d = tmr.count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tmr.expired = (cnt_q == '0) && !tmr.load;
endmodule

//--- hdl/ctcr_host.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Tag memory holds 4096 words of 4 bits; all 4 bits compared.
// [R2] Write strobe low gives a write cycle regardless of output gate.
// [R3] Strobe high: output gate low reads, output gate high compares.
// [R4] Clear input low starts flash clear zeroing the whole array.
// [R5] Compare starts on valid address; hit valid only with strobe and gate high.
// [R6] Hit is one when addressed word equals tag bus input.
// [R7] Hit is zero when any bit differs.
// [R8] Hit output is always driven, never high impedance.
// [R9] Comparator runs continuously, following address and tag bus.
// [R10] Controller holds address and write data stable around write strobe rise.
// [R11] Controller keeps write strobe low at least 16 ns.
// [R12] Hit is invalid during writes; controller does not sample it.
// [R13] Read: stable address, strobe high, data on bus while gate low.
// [R14] Gate held low, outputs follow each new address.
// [R15] Hit is invalid during reads; controller ignores it.
// [R16] Cycle time equals compare access time: 20, 25 or 35 ns.
// [R17] Hit valid within 20 ns of address valid.
// [R18] Hit valid within 12 ns of tag input valid.
// [R19] Read data valid within 10 ns of output gate falling.
// [R20] Wider tags combine several hit outputs through a NAND.
// [R21] During clear, strobes ignored and tag bus high impedance.
// [R22] Hit is invalid while clear input is held low.
// [R23] Controller holds clear input low at least 36 ns.
// [R24] Device tag bus stays high impedance during compare.
// [R25] Model drives hit low whenever it is invalid.
module ctcr_host #(
  parameter int ADDR_W = ctcr_pkg::ADDR_W,
  parameter int TAG_W  = ctcr_pkg::TAG_W,
  parameter int NDEV   = 1
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              req_valid,
  input  wire logic [1:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [TAG_W-1:0]  req_tag,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic                   rsp_hit,
  output logic [TAG_W-1:0]       rsp_tag,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   write_n,
  output logic                   out_gate_n,
  output logic                   clear_all_n,
  output logic [TAG_W-1:0]       tag_o,
  output logic                   tag_oe,
  input  wire logic [TAG_W-1:0]  tag_i,
  input  wire logic [NDEV-1:0]   hit_i
);
  // Registered pin and response state
  ctcr_pkg::ctcr_state_t st_q;
  ctcr_pkg::ctcr_state_t st_d;
  logic [1:0]            op_q;
  logic [1:0]            op_d;
  logic [ADDR_W-1:0]     addr_q;
  logic [ADDR_W-1:0]     addr_d;
  logic [TAG_W-1:0]      tag_q;
  logic [TAG_W-1:0]      tag_d;
  logic                  tag_oe_q;
  logic                  tag_oe_d;
  logic                  we_n_q;
  logic                  we_n_d;
  logic                  oe_n_q;
  logic                  oe_n_d;
  logic                  clr_n_q;
  logic                  clr_n_d;
  logic                  rdy_q;
  logic                  rdy_d;
  logic                  rv_q;
  logic                  rv_d;
  logic                  rhit_q;
  logic                  rhit_d;
  logic [TAG_W-1:0]      rtag_q;
  logic [TAG_W-1:0]      rtag_d;
  logic                  all_hit;

  // Shared down-counter for strobe widths and cycle spacing
  ctcr_tmr_if tmr ();
  ctcr_timer u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tmr     (tmr)
  );

  // Wide tag: every device must hit; the NAND of hits is a miss flag
  assign all_hit = ~(~&hit_i); // see [R8] [R9] [R20]

  // Strobe width or access time per operation, in clock cycles
  function automatic logic [ctcr_pkg::CNT_W-1:0] wait_for(input logic [1:0] op);
    unique case (op)
      ctcr_pkg::OP_WRITE: wait_for = ctcr_pkg::CNT_W'(ctcr_pkg::WEW_CYC); // see [R11]
      ctcr_pkg::OP_CLEAR: wait_for = ctcr_pkg::CNT_W'(ctcr_pkg::CLP_CYC); // see [R23]
      ctcr_pkg::OP_READ:  wait_for = ctcr_pkg::CNT_W'(ctcr_pkg::AA_CYC); // see [R19]
      // Address and tag driven together: the longer of both access times
      ctcr_pkg::OP_COMPARE: wait_for = ctcr_pkg::CNT_W'(ctcr_pkg::ACA_CYC); // see [R17] [R18]
    endcase
  endfunction

  always_comb begin
    st_d     = st_q;
    op_d     = op_q;
    addr_d   = addr_q;
    tag_d    = tag_q;
    tag_oe_d = tag_oe_q;
    we_n_d   = we_n_q;
    oe_n_d   = oe_n_q;
    clr_n_d  = clr_n_q;
    rdy_d    = rdy_q;
    rv_d     = 1'b0;
    rhit_d   = rhit_q;
    rtag_d   = rtag_q;
    tmr.load  = 1'b0;
    tmr.count = '0;
    unique case (st_q)
      ctcr_pkg::CTCR_IDLE: begin
        if (req_valid && rdy_q) begin
          rdy_d  = 1'b0;
          op_d   = req_op;
          addr_d = req_addr; // see [R5] [R13]
          tag_d  = req_tag; // see [R1]
          // Bus only driven for compare input or write data
          tag_oe_d = (req_op == ctcr_pkg::OP_COMPARE) || (req_op == ctcr_pkg::OP_WRITE); // see [R24] [R21]
          if (req_op == ctcr_pkg::OP_READ) begin
            oe_n_d = 1'b0; // see [R3] [R14]
          end
          tmr.load  = 1'b1;
          tmr.count = ctcr_pkg::CNT_W'(ctcr_pkg::DS_CYC);
          st_d = ctcr_pkg::CTCR_SETUP;
        end else if (!rdy_q && !req_valid) begin
          // Out of reset, ready waits until the request line has been low once
          rdy_d = 1'b1;
        end
      end
      ctcr_pkg::CTCR_SETUP: begin
        // Strobe falls a cycle after address, tag and gate have settled
        tmr.load  = 1'b1;
        tmr.count = wait_for(op_q);
        if (op_q == ctcr_pkg::OP_WRITE) begin
          we_n_d = 1'b0; // see [R2] [R10]
        end else if (op_q == ctcr_pkg::OP_CLEAR) begin
          clr_n_d = 1'b0; // see [R4]
        end
        st_d = ctcr_pkg::CTCR_STROBE;
      end
      ctcr_pkg::CTCR_STROBE: begin
        if (tmr.expired) begin
          // Strobes release while address and data still stand
          we_n_d  = 1'b1; // see [R10] [R11]
          clr_n_d = 1'b1; // see [R23]
          st_d = ctcr_pkg::CTCR_WAIT;
        end
      end
      ctcr_pkg::CTCR_WAIT: begin
        // Hit only sampled in compare, never in write, read or clear
        if (op_q == ctcr_pkg::OP_COMPARE) begin
          rhit_d = all_hit; // see [R5] [R6] [R7] [R12] [R15] [R22]
        end else begin
          rhit_d = 1'b0; // see [R25]
        end
        rtag_d = (op_q == ctcr_pkg::OP_READ) ? tag_i : '0; // see [R13]
        oe_n_d   = 1'b1;
        tag_oe_d = 1'b0;
        rv_d     = 1'b1;
        tmr.load  = 1'b1;
        tmr.count = ctcr_pkg::CNT_W'(ctcr_pkg::CYC_MIN - 1);
        st_d = ctcr_pkg::CTCR_DONE;
      end
      ctcr_pkg::CTCR_DONE: begin
        // Keep successive cycles apart by the minimum cycle time
        if (tmr.expired) begin
          rdy_d = 1'b1; // see [R16]
          st_d  = ctcr_pkg::CTCR_IDLE;
        end
      end
      default: begin
        st_d = ctcr_pkg::CTCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= ctcr_pkg::CTCR_IDLE;
      op_q     <= ctcr_pkg::OP_COMPARE;
      addr_q   <= '0;
      tag_q    <= '0;
      tag_oe_q <= 1'b0;
      we_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      clr_n_q  <= 1'b1;
      rdy_q    <= 1'b0;
      rv_q     <= 1'b0;
      rhit_q   <= 1'b0;
      rtag_q   <= '0;
    end else begin
      st_q     <= st_d;
      op_q     <= op_d;
      addr_q   <= addr_d;
      tag_q    <= tag_d;
      tag_oe_q <= tag_oe_d;
      we_n_q   <= we_n_d;
      oe_n_q   <= oe_n_d;
      clr_n_q  <= clr_n_d;
      rdy_q    <= rdy_d;
      rv_q     <= rv_d;
      rhit_q   <= rhit_d;
      rtag_q   <= rtag_d;
    end
  end

  assign req_ready   = rdy_q;
  assign rsp_valid   = rv_q;
  assign rsp_hit     = rhit_q;
  assign rsp_tag     = rtag_q;
  assign mem_addr    = addr_q;
  assign write_n     = we_n_q;
  assign out_gate_n  = oe_n_q;
  assign clear_all_n = clr_n_q;
  assign tag_o       = tag_q;
  assign tag_oe      = tag_oe_q;
endmodule

//--- tb/ctcr_host_props.sv
`timescale 1ns/1ps
module ctcr_host_props #(
  parameter int ADDR_W = 12,
  parameter int TAG_W  = 4,
  parameter int NDEV   = 1
) (
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic              req_valid,
  input wire logic [1:0]        req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [TAG_W-1:0]  req_tag,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              rsp_hit,
  input wire logic [TAG_W-1:0]  rsp_tag,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              write_n,
  input wire logic              out_gate_n,
  input wire logic              clear_all_n,
  input wire logic [TAG_W-1:0]  tag_o,
  input wire logic              tag_oe,
  input wire logic [TAG_W-1:0]  tag_i,
  input wire logic [NDEV-1:0]   hit_i
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_take; req_valid && req_ready |=> !req_ready; endproperty
  a_take: assert property (p_take) else $error("ready held after take");
  property p_wew; $fell(write_n) |-> !write_n [*2]; endproperty
  a_wew: assert property (p_wew) else $error("write strobe too short");
  property p_clp; $fell(clear_all_n) |-> !clear_all_n [*5]; endproperty
  a_clp: assert property (p_clp) else $error("clear pulse too short");
  property p_whold;
    !write_n && !$past(write_n) |-> $stable(mem_addr) && $stable(tag_o) && tag_oe;
  endproperty
  a_whold: assert property (p_whold) else $error("write data moved");
  property p_wend;
    $rose(write_n) |-> $stable(mem_addr) && $stable(tag_o) && tag_oe;
  endproperty
  a_wend: assert property (p_wend) else $error("write data gone at strobe rise");
  property p_clr; !clear_all_n |-> write_n && out_gate_n && !tag_oe; endproperty
  a_clr: assert property (p_clr) else $error("strobe during clear");
  property p_rd; !out_gate_n |-> !tag_oe && write_n; endproperty
  a_rd: assert property (p_rd) else $error("bus driven during read");
  property p_ans;
    req_valid && req_ready && (req_op == ctcr_pkg::OP_COMPARE || req_op == ctcr_pkg::OP_READ)
      |-> ##7 rsp_valid;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer in time");
  property p_ans_wr;
    req_valid && req_ready && req_op == ctcr_pkg::OP_WRITE |-> ##6 rsp_valid;
  endproperty
  a_ans_wr: assert property (p_ans_wr) else $error("no write answer in time");
  property p_ans_clr;
    req_valid && req_ready && req_op == ctcr_pkg::OP_CLEAR |-> ##9 rsp_valid;
  endproperty
  a_ans_clr: assert property (p_ans_clr) else $error("no clear answer in time");
  property p_pulse; rsp_valid |=> !rsp_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("answer not a pulse");
endmodule

//--- tb/ctcr_dev_model.sv
`timescale 1ns/1ps
module ctcr_dev_model (
  input wire logic [11:0] mem_addr,
  input wire logic        write_n,
  input wire logic        out_gate_n,
  input wire logic        clear_all_n,
  input wire logic [3:0]  tag_o,
  input wire logic        tag_oe,
  output logic     [3:0]  tag_i,
  output logic            hit
);
  logic [3:0] mem [4096];
  logic       rd;
  logic       wr_low = 1'b0;
  initial for (int i = 0; i < 4096; i++) mem[i] = 4'h0;
  // Store only on a rise that follows a low phase, never on the first level out of reset
  always @(write_n or clear_all_n) begin
    if (clear_all_n === 1'b0) begin
      for (int i = 0; i < 4096; i++) mem[i] = 4'h0;
    end else if (wr_low && write_n === 1'b1) begin
      mem[mem_addr] = tag_o;
    end
    wr_low = (write_n === 1'b0);
  end
  assign rd = write_n && !out_gate_n && clear_all_n;
  // Released bus floats to the pull-up level
  assign tag_i = tag_oe ? tag_o : (rd ? mem[mem_addr] : 4'hF);
  // Compare runs all the time, forced low whenever invalid
  assign hit = (write_n && out_gate_n && clear_all_n) && (mem[mem_addr] == tag_i);
  // Also covers
endmodule

//--- tb/test_cache_tag_compare_ram.sv
`timescale 1ns/1ps
module test_cache_tag_compare_ram;
  logic        sys_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0;
  logic [1:0]  req_op = 2'h0;
  logic [11:0] req_addr = 12'h000, mem_addr;
  logic [3:0]  req_tag = 4'h0, rsp_tag, tag_o, tag_i;
  logic        req_ready, rsp_valid, rsp_hit, write_n, out_gate_n, clear_all_n, tag_oe, hit;
  logic [3:0]  ref_mem [4096];
  int          n_mismatch = 0, comparisons = 0, seed = 32'hFF83D86F;
  ctcr_host ctcr_host_inst (.sys_clk, .rst_b, .req_valid, .req_op, .req_addr, .req_tag,
    .req_ready, .rsp_valid, .rsp_hit, .rsp_tag, .mem_addr, .write_n, .out_gate_n,
    .clear_all_n, .tag_o, .tag_oe, .tag_i, .hit_i(hit));
  ctcr_dev_model ctcr_dev_model_inst (.mem_addr, .write_n, .out_gate_n, .clear_all_n,
    .tag_o, .tag_oe, .tag_i, .hit);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [3:0] exp_hit(input logic [11:0] a, input logic [3:0] t);
    return {3'h0, ref_mem[a] === t};
  endfunction
  task automatic op(input logic [1:0] o, input logic [11:0] a, input logic [3:0] t);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_tag <= t;
    do @(posedge sys_clk); while (req_ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    do @(posedge sys_clk); while (rsp_valid !== 1'b1 && ++n < 100);
    if (n >= 100) n_mismatch++;
    case (o)
      ctcr_pkg::OP_COMPARE: check({3'h0, rsp_hit}, exp_hit(a, t));
      ctcr_pkg::OP_READ: begin
        check(rsp_tag, ref_mem[a]);
        check({3'h0, rsp_hit}, 4'h0);
      end
      ctcr_pkg::OP_WRITE: begin
        check({3'h0, rsp_hit}, 4'h0);
        ref_mem[a] = t;
      end
      default: begin
        check({3'h0, rsp_hit}, 4'h0);
        foreach (ref_mem[i]) ref_mem[i] = 4'h0;
      end
    endcase
  endtask
  initial begin
    #40000;
    n_mismatch++;
    results;
  end
  initial begin
    logic [31:0] r;
    logic [11:0] a;
    foreach (ref_mem[i]) ref_mem[i] = 4'h0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      op(ctcr_pkg::OP_WRITE, 12'h800, 4'hF);
      op(ctcr_pkg::OP_COMPARE, 12'h800, 4'hF ^ (4'h1 << b));
    end
    op(ctcr_pkg::OP_COMPARE, 12'h800, 4'hF);
    $display("test single bit miss done");
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      a = (r[0] ? 12'hFFF : 12'h000) ^ {9'h0, r[3:1]};
      op(r[13:12], a, r[4] ? ref_mem[a] : r[11:8]);
    end
    $display("test random done");
    op(ctcr_pkg::OP_WRITE, 12'hFFF, 4'hA);
    op(ctcr_pkg::OP_CLEAR, 12'h000, 4'h0);
    op(ctcr_pkg::OP_READ, 12'hFFF, 4'h0);
    op(ctcr_pkg::OP_COMPARE, 12'hFFF, 4'h0);
    $display("test clear done");
    results;
  end
endmodule
bind ctcr_host ctcr_host_props #(.ADDR_W(ADDR_W), .TAG_W(TAG_W), .NDEV(NDEV))
  ctcr_host_props_inst (.sys_clk, .rst_b, .req_valid, .req_op, .req_addr, .req_tag,
  .req_ready, .rsp_valid, .rsp_hit, .rsp_tag, .mem_addr, .write_n, .out_gate_n,
  .clear_all_n, .tag_o, .tag_oe, .tag_i, .hit_i);
